// ### logic/pss_phy_status_summary.sv
`timescale 1ns/100ps

// Behaviour
// RL1 - summary register sits at index 10h, 16 bits, read-only
// RL2 - bits 15 and 7 read zero, writes to them ignored
// RL3 - bit 14 reads 1 when pairs swapped, 0 when normal
// RL4 - crossover bit follows enable/force control, live when enabled not forced
// RL5 - bit 13 latches receive error, cleared by reading receive error counter 15h
// RL6 - bit 12 mirrors polarity latch, cleared by 10BASE status read only
// RL7 - bit 11 latches false carrier, cleared by reading false carrier counter 14h
// RL8 - bit 10 latched-low signal detect, qualified by lock when 16h bit 8 set
// RL9 - bit 9 latched-low descrambler lock
// RL10 - bit 8 page received, cleared by expansion register 06h read, not summary
// RL11 - bit 6 remote fault, cleared by basic status 01h read or reset
// RL12 - bit 0 mirrors link status, not cleared by summary read
// RL13 - bit 1 reads 1 for 10 Mb/s, 0 for 100 Mb/s
// RL14 - bit 2 reads 1 for full duplex, 0 for half
// RL15 - bit 4 set once auto-negotiation complete, else 0
// RL16 - latched-low bits hold zero until next summary read, then reload live
module pss_phy_status_summary
  import pss_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [PSS_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [PSS_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pss_phy_in_t phy_in,
  output logic irq
);

  localparam int IN_W = $bits(pss_phy_in_t);
  localparam int WI_W = ADDR_W - 2;

  // index compare needs room for every 8-bit index
  if (ADDR_W < PSS_IDX_W + 2 || ADDR_W > PSS_DATA_W) begin : g_bad_addr_w
    $error("ADDR_W out of range");
  end

  // two-stage synchroniser per status bit; stage one feeds stage two only
  logic [IN_W-1:0] sync_a;
  logic [IN_W-1:0] sync_b;
  genvar gi;
  generate
    for (gi = 0; gi < IN_W; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
        end else if (ce) begin
          sync_a[gi] <= phy_in[gi];
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate

  pss_phy_in_t live;
  assign live = pss_phy_in_t'(sync_b);

  // apb decode
  pss_state_t state;
  pss_state_t next_state;
  logic [WI_W-1:0] word_idx;
  logic setup;
  logic fire;
  logic rd_fire;
  logic wr_fire;
  assign word_idx = paddr[ADDR_W-1:2];
  // a setup missed while frozen is taken at the next enabled edge, so data is never stale
  assign setup = psel && (state == PSS_IDLE);
  // no waits of its own; ce low stretches the access phase
  assign pready = ce && (state == PSS_ACCESS);
  assign fire = psel && penable && ce && (state == PSS_ACCESS);
  assign rd_fire = fire && !pwrite;
  assign wr_fire = fire && pwrite;

  function automatic logic hit(input logic [PSS_IDX_W-1:0] idx);
    hit = (paddr[1:0] == 2'b00) && (word_idx == WI_W'(idx));
  endfunction

  logic hit_basic, hit_expansion, hit_summary, hit_false_carrier, hit_rx_error;
  logic hit_signal_qual, hit_control, hit_tenbase, hit_irq_status, hit_irq_mask, mapped;
  assign hit_basic = hit(IDX_BASIC_STATUS);
  assign hit_expansion = hit(IDX_AN_EXPANSION);
  assign hit_summary = hit(IDX_SUMMARY);
  assign hit_false_carrier = hit(IDX_FALSE_CARRIER);
  assign hit_rx_error = hit(IDX_RX_ERROR_CNT);
  assign hit_signal_qual = hit(IDX_SIGNAL_QUAL);
  assign hit_control = hit(IDX_PHY_CONTROL);
  assign hit_tenbase = hit(IDX_TENBASE_STATUS);
  assign hit_irq_status = hit(IDX_IRQ_STATUS);
  assign hit_irq_mask = hit(IDX_IRQ_MASK);
  assign mapped = hit_basic || hit_expansion || hit_summary || hit_false_carrier ||
                  hit_rx_error || hit_signal_qual || hit_control || hit_tenbase ||
                  hit_irq_status || hit_irq_mask;

  // read side effects happen only at the completing edge
  logic clr_basic, clr_expansion, clr_false_carrier, clr_rx_error, clr_tenbase;
  logic rd_summary, rd_irq_status;
  assign clr_basic = rd_fire && hit_basic;
  assign clr_expansion = rd_fire && hit_expansion;
  assign clr_false_carrier = rd_fire && hit_false_carrier;
  assign clr_rx_error = rd_fire && hit_rx_error;
  assign clr_tenbase = rd_fire && hit_tenbase;
  assign rd_summary = rd_fire && hit_summary;
  assign rd_irq_status = rd_fire && hit_irq_status;

  // transfer phase tracking
  always_comb begin
    next_state = state;
    case (state)
      PSS_IDLE: begin
        if (setup) begin
          next_state = PSS_ACCESS;
        end
      end
      PSS_ACCESS: begin
        if (fire) begin
          next_state = PSS_IDLE;
        end
      end
      default: begin
        next_state = PSS_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= PSS_IDLE;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // software control registers, byte lanes honoured
  logic [PSS_REG_W-1:0] phy_control;
  logic [PSS_REG_W-1:0] signal_qual;
  logic [PSS_N_EV-1:0] irq_mask;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phy_control <= PHY_CONTROL_RESET;
      signal_qual <= SIGNAL_QUAL_RESET;
      irq_mask <= IRQ_RESET;
    end else if (wr_fire) begin
      if (hit_control) begin
        if (pstrb[0]) phy_control[7:0] <= pwdata[7:0];
        if (pstrb[1]) phy_control[15:8] <= pwdata[15:8];
      end
      if (hit_signal_qual) begin
        if (pstrb[0]) signal_qual[7:0] <= pwdata[7:0];
        if (pstrb[1]) signal_qual[15:8] <= pwdata[15:8];
      end
      if (hit_irq_mask && pstrb[0]) begin
        irq_mask <= pwdata[PSS_N_EV-1:0];
      end
    end
  end

  // latched-high bits: a set in the clearing cycle wins
  logic rx_err_lat, false_carrier_lat, polarity_lat, page_lat, remote_fault_lat, jabber_lat;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_err_lat <= 1'b0;
      false_carrier_lat <= 1'b0;
      polarity_lat <= 1'b0;
      page_lat <= 1'b0;
      remote_fault_lat <= 1'b0;
      jabber_lat <= 1'b0;
    end else if (ce) begin
      // RL5 receive error latch
      rx_err_lat <= live.rx_error || (rx_err_lat && !clr_rx_error);
      // RL7 false carrier latch
      false_carrier_lat <= live.false_carrier || (false_carrier_lat && !clr_false_carrier);
      // RL6 polarity latch
      polarity_lat <= live.polarity_inverted || (polarity_lat && !clr_tenbase);
      // RL10 page received latch
      page_lat <= live.page_received || (page_lat && !clr_expansion);
      // RL11 remote fault latch
      remote_fault_lat <= live.remote_fault || (remote_fault_lat && !clr_basic);
      jabber_lat <= live.jabber || (jabber_lat && !clr_basic);
    end
  end

  // latched-low bits: zero sticks until the summary is read
  logic qual_signal_detect;
  logic signal_detect_lat;
  logic lock_lat;
  // RL8 qualify detect with lock on request
  assign qual_signal_detect = live.raw_signal_detect &&
                              (live.descrambler_lock || !signal_qual[BIT_SIGNAL_QUAL_EN]);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      signal_detect_lat <= 1'b0;
      lock_lat <= 1'b0;
    end else if (ce) begin
      // RL16 reload live on summary read
      signal_detect_lat <= rd_summary ? qual_signal_detect :
                           (signal_detect_lat && qual_signal_detect);
      // RL9 lock latched low
      lock_lat <= rd_summary ? live.descrambler_lock : (lock_lat && live.descrambler_lock);
    end
  end

  // crossover: off when disabled, swapped when forced, else live
  logic crossover_bit;
  // RL4 enable and force steer
  assign crossover_bit = phy_control[BIT_CROSSOVER_ENABLE] &&
                         (phy_control[BIT_CROSSOVER_FORCE] || live.crossover_swapped);

  // summary word assembly
  logic [PSS_REG_W-1:0] summary;
  always_comb begin
    summary = SUMMARY_RESET;
    // RL3 pair assignment
    summary[BIT_CROSSOVER] = crossover_bit;
    summary[BIT_RX_ERROR] = rx_err_lat;
    summary[BIT_POLARITY] = polarity_lat;
    summary[BIT_FALSE_CARRIER] = false_carrier_lat;
    summary[BIT_SIGNAL_DETECT] = signal_detect_lat;
    summary[BIT_DESCR_LOCK] = lock_lat;
    summary[BIT_PAGE_RX] = page_lat;
    summary[BIT_REMOTE_FAULT] = remote_fault_lat;
    summary[BIT_JABBER] = jabber_lat;
    // RL15 negotiation complete
    summary[BIT_AN_COMPLETE] = live.an_complete;
    summary[BIT_LOOPBACK] = live.loopback;
    // RL14 duplex
    summary[BIT_DUPLEX] = live.full_duplex;
    // RL13 speed
    summary[BIT_SPEED_10] = live.speed_10;
    // RL12 link mirror
    summary[BIT_LINK] = live.link_up;
    // RL2 reserved bits zero
    summary = summary & ~SUMMARY_RSVD_MASK;
  end

  // interrupt events: rising edges of the synchronised levels, either edge of link for link change
  logic [PSS_N_EV-1:0] ev_level;
  logic [PSS_N_EV-1:0] ev_prev;
  logic [PSS_N_EV-1:0] ev_pulse;
  logic [PSS_N_EV-1:0] irq_status;
  logic link_prev;
  always_comb begin
    ev_level = '0;
    ev_level[EV_RX_ERROR] = live.rx_error;
    ev_level[EV_FALSE_CARRIER] = live.false_carrier;
    ev_level[EV_PAGE_RX] = live.page_received;
    ev_level[EV_REMOTE_FAULT] = live.remote_fault;
    ev_level[EV_LINK_CHANGE] = 1'b0;
  end
  always_comb begin
    ev_pulse = ev_level & ~ev_prev;
    ev_pulse[EV_LINK_CHANGE] = live.link_up ^ link_prev;
  end

  // only bits already reported by this read are cleared
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_prev <= IRQ_RESET;
      link_prev <= 1'b0;
      irq_status <= IRQ_RESET;
    end else if (ce) begin
      ev_prev <= ev_level;
      link_prev <= live.link_up;
      irq_status <= ev_pulse |
                    (irq_status & ~(rd_irq_status ? prdata[PSS_N_EV-1:0] : IRQ_RESET));
    end
  end

  assign irq = |(irq_status & irq_mask);

  // read data captured in the setup cycle, held through the access phase
  logic [PSS_REG_W-1:0] rd_word;
  always_comb begin
    rd_word = '0;
    if (hit_summary) begin
      rd_word = summary;
    end else if (hit_control) begin
      rd_word = phy_control;
    end else if (hit_signal_qual) begin
      rd_word = signal_qual;
    end else if (hit_irq_status) begin
      rd_word = {{(PSS_REG_W-PSS_N_EV){1'b0}}, irq_status};
    end else if (hit_irq_mask) begin
      rd_word = {{(PSS_REG_W-PSS_N_EV){1'b0}}, irq_mask};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (ce && setup) begin
      // RL1 summary at its index
      prdata <= pwrite ? '0 : {{(PSS_DATA_W-PSS_REG_W){1'b0}}, rd_word};
      pslverr <= !mapped;
    end
  end

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_summary_read;
    ce && setup && !pwrite && hit_summary |=> prdata[PSS_REG_W-1:0] == $past(summary);
  endproperty
  a_summary_read: assert property (p_summary_read) else $error("summary read data wrong"); // RL1
  property p_reserved;
    ce && setup && !pwrite && hit_summary |=> !prdata[15] && !prdata[7];
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set"); // RL2
  // pin level two enabled edges back must show when live crossover applies
  property p_crossover;
    ce [*3] ##0 (phy_control[BIT_CROSSOVER_ENABLE] && !phy_control[BIT_CROSSOVER_FORCE])
      |-> summary[BIT_CROSSOVER] == $past(phy_in.crossover_swapped, 2);
  endproperty
  a_crossover: assert property (p_crossover) else $error("crossover not live"); // RL3
  property p_crossover_off;
    !phy_control[BIT_CROSSOVER_ENABLE] |-> !summary[BIT_CROSSOVER];
  endproperty
  a_crossover_off: assert property (p_crossover_off) else $error("crossover when off"); // RL4
  property p_rx_err_hold;
    ce && live.rx_error ##1 (!clr_rx_error) [*2] |=> summary[BIT_RX_ERROR];
  endproperty
  a_rx_err_hold: assert property (p_rx_err_hold) else $error("rx error latch lost"); // RL5
  property p_polarity_keep;
    summary[BIT_POLARITY] && rd_summary && !clr_tenbase |=> summary[BIT_POLARITY];
  endproperty
  a_polarity_keep: assert property (p_polarity_keep) else $error("polarity cleared"); // RL6
  property p_false_carrier_clr;
    clr_false_carrier && !live.false_carrier |=> !summary[BIT_FALSE_CARRIER];
  endproperty
  a_false_carrier_clr: assert property (p_false_carrier_clr) else $error("fc not cleared"); // RL7
  property p_detect_low;
    ce && !qual_signal_detect ##1 !rd_summary [*3] |-> !summary[BIT_SIGNAL_DETECT];
  endproperty
  a_detect_low: assert property (p_detect_low) else $error("detect low not held"); // RL8
  property p_lock_reload;
    rd_summary && live.descrambler_lock |=> summary[BIT_DESCR_LOCK];
  endproperty
  a_lock_reload: assert property (p_lock_reload) else $error("lock not reloaded"); // RL16
  property p_page_keep;
    summary[BIT_PAGE_RX] && rd_summary |=> summary[BIT_PAGE_RX];
  endproperty
  a_page_keep: assert property (p_page_keep) else $error("page cleared by summary"); // RL10
  property p_fault_clr;
    clr_basic && !live.remote_fault |=> !summary[BIT_REMOTE_FAULT];
  endproperty
  a_fault_clr: assert property (p_fault_clr) else $error("fault not cleared"); // RL11
  // link bit tracks the pin through the two synchroniser stages
  property p_link;
    ce [*3] |-> summary[BIT_LINK] == $past(phy_in.link_up, 2);
  endproperty
  a_link: assert property (p_link) else $error("link not mirrored"); // RL12

  c_summary_read: cover property (rd_summary && summary[BIT_RX_ERROR]);
  c_lock_reload: cover property (!summary[BIT_DESCR_LOCK] ##1 rd_summary ##1
                                 summary[BIT_DESCR_LOCK]);
  c_irq: cover property ($rose(irq));
  c_slverr: cover property (fire && pslverr);

endmodule

// ### logic/pss_pkg.sv
package pss_pkg;

  localparam int PSS_DATA_W = 32;
  localparam int PSS_REG_W = 16;
  localparam int PSS_IDX_W = 8;

  // register indices; byte address is four times the index
  localparam logic [PSS_IDX_W-1:0] IDX_BASIC_STATUS = 8'h01;
  localparam logic [PSS_IDX_W-1:0] IDX_AN_EXPANSION = 8'h06;
  localparam logic [PSS_IDX_W-1:0] IDX_SUMMARY = 8'h10;
  localparam logic [PSS_IDX_W-1:0] IDX_FALSE_CARRIER = 8'h14;
  localparam logic [PSS_IDX_W-1:0] IDX_RX_ERROR_CNT = 8'h15;
  localparam logic [PSS_IDX_W-1:0] IDX_SIGNAL_QUAL = 8'h16;
  localparam logic [PSS_IDX_W-1:0] IDX_PHY_CONTROL = 8'h19;
  localparam logic [PSS_IDX_W-1:0] IDX_TENBASE_STATUS = 8'h1A;
  localparam logic [PSS_IDX_W-1:0] IDX_IRQ_STATUS = 8'h1C;
  localparam logic [PSS_IDX_W-1:0] IDX_IRQ_MASK = 8'h1D;

  // summary register bit positions
  localparam int BIT_CROSSOVER = 14;
  localparam int BIT_RX_ERROR = 13;
  localparam int BIT_POLARITY = 12;
  localparam int BIT_FALSE_CARRIER = 11;
  localparam int BIT_SIGNAL_DETECT = 10;
  localparam int BIT_DESCR_LOCK = 9;
  localparam int BIT_PAGE_RX = 8;
  localparam int BIT_REMOTE_FAULT = 6;
  localparam int BIT_JABBER = 5;
  localparam int BIT_AN_COMPLETE = 4;
  localparam int BIT_LOOPBACK = 3;
  localparam int BIT_DUPLEX = 2;
  localparam int BIT_SPEED_10 = 1;
  localparam int BIT_LINK = 0;
  localparam logic [PSS_REG_W-1:0] SUMMARY_RSVD_MASK = 16'h8080;
  localparam logic [PSS_REG_W-1:0] SUMMARY_RESET = 16'h0000;

  // control fields
  localparam int BIT_CROSSOVER_ENABLE = 15;
  localparam int BIT_CROSSOVER_FORCE = 14;
  localparam int BIT_SIGNAL_QUAL_EN = 8;
  localparam logic [PSS_REG_W-1:0] PHY_CONTROL_RESET = 16'h8000;
  localparam logic [PSS_REG_W-1:0] SIGNAL_QUAL_RESET = 16'h0000;

  // interrupt event bits
  localparam int EV_RX_ERROR = 0;
  localparam int EV_FALSE_CARRIER = 1;
  localparam int EV_PAGE_RX = 2;
  localparam int EV_REMOTE_FAULT = 3;
  localparam int EV_LINK_CHANGE = 4;
  localparam int PSS_N_EV = 5;
  localparam logic [PSS_N_EV-1:0] IRQ_RESET = 5'h00;

  // live status from the transceiver core, all levels
  typedef struct packed {
    logic crossover_swapped;
    logic rx_error;
    logic polarity_inverted;
    logic false_carrier;
    logic raw_signal_detect;
    logic descrambler_lock;
    logic page_received;
    logic remote_fault;
    logic jabber;
    logic an_complete;
    logic loopback;
    logic full_duplex;
    logic speed_10;
    logic link_up;
  } pss_phy_in_t;

  typedef enum logic [1:0] {
    PSS_IDLE = 2'b01,
    PSS_ACCESS = 2'b10
  } pss_state_t;

endpackage

// ### verification/pss_core_model.sv
`timescale 1ns/100ps

// stands in for the transceiver core that feeds live status levels
module pss_core_model
  import pss_pkg::*;
(
  input wire logic pclk,
  output pss_phy_in_t phy_in
);
  initial begin
    phy_in = '0;
  end

  // change just after an edge, then hold well past the two-flop synchroniser
  task automatic drive(input logic [13:0] v);
    @(posedge pclk);
    phy_in <= pss_phy_in_t'(v);
    repeat (5) @(posedge pclk);
  endtask
endmodule

// ### verification/pss_phy_status_summary_tb.sv
`timescale 1ns/100ps

module pss_phy_status_summary_tb
  import pss_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  pss_phy_in_t phy_in;
  logic [31:0] rd;
  logic er;
  logic [15:0] ex;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;
  int i;

  // address and value tables for the looped cases
  localparam logic [11:0] RST_A [6] = '{12'h040, 12'h064, 12'h058, 12'h074, 12'h070, 12'h054};
  localparam logic [15:0] RST_V [6] = '{16'h0000, 16'h8000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000};
  localparam logic [11:0] BAD_A [2] = '{12'h0C0, 12'h041};
  localparam logic [11:0] CLR_A [5] = '{12'h054, 12'h050, 12'h068, 12'h018, 12'h004};
  localparam logic [15:0] CLR_M [5] = '{16'h2000, 16'h0800, 16'h1000, 16'h0100, 16'h0060};
  localparam logic [15:0] XO_C [5] = '{16'h0000, 16'h8000, 16'hC000, 16'h8000, 16'h4000};
  localparam logic XO_S [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
  localparam logic XO_E [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
  localparam logic [15:0] SQ_C [3] = '{16'h0100, 16'h0000, 16'h0100};
  localparam logic [13:0] SQ_P [3] = '{14'h0200, 14'h0200, 14'h0300};
  localparam logic [15:0] SQ_E [3] = '{16'h0000, 16'h0400, 16'h0400};

  always #5 pclk = ~pclk;

  pss_phy_status_summary #(
    .ADDR_W(12)
  ) i_dut (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .phy_in(phy_in),
    .irq(irq)
  );

  pss_core_model i_core (
    .pclk(pclk),
    .phy_in(phy_in)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen high
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= wr ? 4'h3 : 4'h0;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [15:0] m, input logic [15:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk({rd[31:16], rd[15:0] & m}, {16'h0000, e & m});
    chk({31'h0000_0000, er}, 32'h0000_0000);
  endtask

  // irq comes from registers, so give it time to settle
  task automatic irq_chk(input logic e);
    repeat (2) @(negedge pclk);
    chk({31'h0000_0000, irq}, {31'h0000_0000, e});
  endtask

  task automatic tally_and_finish();
    if (n_errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // whole run is a few hundred cycles; the ceiling only catches a hang
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // reset values
    for (i = 0; i < 6; i++) rd_chk(RST_A[i], 16'hFFFF, RST_V[i]);
    // writes to the summary are dropped
    xfer(1'b1, 12'h040, 32'h0000_FFFF);
    rd_chk(12'h040, 16'hFFFF, 16'h0000);
    // unmapped and unaligned accesses are refused
    for (i = 0; i < 2; i++) begin
      xfer(1'b0, BAD_A[i], 32'h0000_0000);
      chk({31'h0000_0000, er}, 32'h0000_0001);
      chk(rd, 32'h0000_0000);
    end
    // every condition at once; latched-low bits only reload on a summary read
    i_core.drive(14'h3FFF);
    irq_chk(1'b0);
    rd_chk(12'h040, 16'hFFFF, 16'h797F);
    rd_chk(12'h040, 16'hFFFF, 16'h7F7F);
    xfer(1'b1, 12'h074, 32'h0000_0002);
    irq_chk(1'b1);
    rd_chk(12'h070, 16'h001F, 16'h001F);
    irq_chk(1'b0);
    // conditions drop; latched bits stay, summary read clears none of them
    i_core.drive(14'h0000);
    rd_chk(12'h040, 16'hFFFF, 16'h3960);
    irq_chk(1'b0);
    xfer(1'b1, 12'h074, 32'h0000_001F);
    irq_chk(1'b1);
    rd_chk(12'h070, 16'h001F, 16'h0010);
    // each clearing read removes its own bits only
    ex = 16'h3960;
    for (i = 0; i < 5; i++) begin
      rd_chk(CLR_A[i], 16'hFFFF, 16'h0000);
      ex = ex & ~CLR_M[i];
      rd_chk(12'h040, 16'hFFFF, ex);
    end
    // one live bit at a time, so swapped positions show up
    for (i = 0; i < 5; i++) begin
      i_core.drive(14'(1 << i));
      rd_chk(12'h040, 16'hFFFF, 16'(1 << i));
    end
    // crossover enable and force combinations
    for (i = 0; i < 5; i++) begin
      xfer(1'b1, 12'h064, {16'h0000, XO_C[i]});
      i_core.drive(XO_S[i] ? 14'h2000 : 14'h0000);
      rd_chk(12'h040, 16'h4000, {1'b0, XO_E[i], 14'h0000});
    end
    // detect qualified by lock only when enabled; first read reloads
    for (i = 0; i < 3; i++) begin
      xfer(1'b1, 12'h058, {16'h0000, SQ_C[i]});
      i_core.drive(SQ_P[i]);
      xfer(1'b0, 12'h040, 32'h0000_0000);
      rd_chk(12'h040, 16'h0400, SQ_E[i]);
    end
    // a short drop is held low until the next summary read
    i_core.drive(14'h0000);
    i_core.drive(14'h0300);
    rd_chk(12'h040, 16'h0600, 16'h0000);
    rd_chk(12'h040, 16'h0600, 16'h0600);
    // frozen across the setup edge: the read completes late, never with stale data
    fork
      rd_chk(12'h074, 16'hFFFF, 16'h001F);
      begin
        @(posedge pclk);
        ce <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({31'h0000_0000, pready}, 32'h0000_0000);
        repeat (2) @(posedge pclk);
        ce <= 1'b1;
      end
    join
    tally_and_finish();
  end
endmodule
